// File: bench/hm_alarm_pon_props.sv
// Purpose: port-level checker for the hour-minute alarm and power-on flag block
// Assumes: ce_i high whenever a minute tick is counted; periodic interrupt held several cycles
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
module hm_alarm_pon_props (
   input wire logic                    core_clk_i,
   input wire logic                    rst_i,
   input wire logic                    ce_i,
   input wire rtc_alarm_pkg::reg_req_t reg_req_i,
   input wire logic              [7:0] reg_rdata_o,
   input wire logic                    min_tick_i,
   input wire logic                    periodic_irq_i,
   input wire logic                    irq_b_req_i,
   input wire logic                    irq_out_a_n_o,
   input wire logic                    irq_out_a_oe_n_o,
   input wire logic                    irq_out_b_n_o,
   input wire logic                    irq_out_b_oe_n_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   localparam int FIRE_AT = rtc_alarm_pkg::ALARM_DELAY_CYC + 1;
   logic [11:0] since_tick_r;
   wire         rd_ok  = ce_i && reg_req_i.rd;
   wire         rd_f   = rd_ok && !reg_req_i.wr && reg_req_i.addr == 4'hf;
   wire         wr_ctl = ce_i && reg_req_i.wr && reg_req_i.addr[3:1] == 3'b111;
   ////////////////////////////////////////////////////////////////////////////
   // cycles since the last minute tick; saturates so an old tick never looks fresh
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) since_tick_r <= 12'hfff;
      else if (ce_i && min_tick_i) since_tick_r <= 12'h000;
      else if (ce_i && since_tick_r != 12'hfff) since_tick_r <= since_tick_r + 12'h001;
   end
   AST_A_LEVEL_LOW: assert property (irq_out_a_n_o == 1'b0)
      else $error("pin a drive value not low");
   AST_ALARM_DELAY: assert property ($fell(irq_out_a_oe_n_o) && !$past(periodic_irq_i) |->
      since_tick_r == 12'(FIRE_AT)) else $error("alarm pin fell at wrong distance from tick");
   AST_A_HOLD: assert property ($rose(irq_out_a_oe_n_o) && !$past(periodic_irq_i, 2) |->
      $past(wr_ctl) || $past(wr_ctl, 2)) else $error("pin a released without a write");
   AST_B_ONLY: assert property (!$past(irq_b_req_i) |-> irq_out_b_oe_n_o)
      else $error("pin b driven without its request");
   AST_PON_RELEASE: assert property (rd_f ##1 reg_rdata_o[4] |->
      irq_out_a_oe_n_o && irq_out_b_oe_n_o) else $error("pin driven while power-on flag set");
   AST_FLAG_PIN: assert property (rd_f ##1 reg_rdata_o[0] |-> !irq_out_a_oe_n_o)
      else $error("flag reads set but pin a released");
   AST_MIN_TOP: assert property (rd_ok && reg_req_i.addr inside {4'h1, 4'hb} |=>
      !reg_rdata_o[7]) else $error("minute top bit not zero");
   AST_HOUR_TOP: assert property (rd_ok && reg_req_i.addr inside {4'h2, 4'hc} |=>
      reg_rdata_o[7:6] == 2'b00) else $error("hour top bits not zero");
   // main scenarios reached
   cover property ($fell(irq_out_a_oe_n_o));
   cover property (periodic_irq_i && !irq_out_a_oe_n_o);
   cover property (rd_f ##1 !reg_rdata_o[4]);
endmodule // hm_alarm_pon_props
bind hm_alarm_pon hm_alarm_pon_props u_props (.core_clk_i, .rst_i, .ce_i, .reg_req_i,
   .reg_rdata_o, .min_tick_i, .periodic_irq_i, .irq_b_req_i, .irq_out_a_n_o,
   .irq_out_a_oe_n_o, .irq_out_b_n_o, .irq_out_b_oe_n_o);

// File: bench/host_model.sv
// Purpose: host controller issuing one-cycle register requests
// Assumes: read data stands from the edge after the request until the next read
// Notes:   idle fields carry inverted values so stale data never looks valid
`timescale 1ns/1ps
module host_model (
   input  wire logic              [7:0] reg_rdata_i,
   input  wire logic                    core_clk_i,
   output rtc_alarm_pkg::reg_req_t      reg_req_o
);
   initial reg_req_o = '0;
   ////////////////////////////////////////////////////////////////////////////
   // request raised after an edge, dropped after the taking edge, data taken one edge later
   task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge core_clk_i);
      reg_req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge core_clk_i);
      reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      @(posedge core_clk_i);
      q = reg_rdata_i;
   endtask
endmodule // host_model

// File: bench/tb_top.sv
// Purpose: self-checking bench for the hour-minute alarm and power-on flag block
// Assumes: clock enable held high; time values kept valid bcd
// Notes:   register model in integers; expected firing cycle derived from 61 us at 40 ns
`timescale 1ns/1ps
module tb_top;
   logic                    core_clk_i = 1'b0;
   logic                    rst_i = 1'b1;
   logic                    min_tick_i = 1'b0;
   logic                    periodic_irq_i = 1'b0;
   logic                    irq_b_req_i = 1'b0;
   logic              [7:0] reg_rdata_o;
   logic              [7:0] q;
   logic                    irq_out_a_n_o, irq_out_a_oe_n_o, irq_out_b_n_o, irq_out_b_oe_n_o;
   rtc_alarm_pkg::reg_req_t reg_req;
   int                      n_mismatch = 0, num_checks = 0, regs[16], m_pon, m_flag, n, cm, am;
   int                      t_fmt[4] = '{1, 0, 1, 1}, t_en[4] = '{1, 1, 1, 0};
   int                      t_ch[4] = '{8'h19, 8'h11, 8'h05, 8'h08};
   int                      t_ah[4] = '{8'h20, 8'h32, 8'h05, 8'h09};
   logic             [31:0] seed = 32'h0000_e1ae;
   always #20 core_clk_i = ~core_clk_i;
   host_model host (.reg_rdata_i(reg_rdata_o), .core_clk_i, .reg_req_o(reg_req));
   hm_alarm_pon dut (.core_clk_i, .rst_i, .ce_i(1'b1), .reg_req_i(reg_req), .reg_rdata_o,
      .min_tick_i, .periodic_irq_i, .irq_b_req_i, .irq_out_a_n_o, .irq_out_a_oe_n_o,
      .irq_out_b_n_o, .irq_out_b_oe_n_o);
   ////////////////////////////////////////////////////////////////////////////
   // model helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
   endfunction
   function automatic int bcd(input int v);
      return (v / 10) * 16 + v % 10;
   endfunction
   function automatic int m_en();
      return regs[14][6] && !m_pon;
   endfunction
   function automatic int exp_rd(input int a);
      case (a)
         1, 11: return regs[a] & 8'h7f;
         2, 12: return regs[a] & 8'h3f;
         7: return m_pon ? 0 : regs[a] & 8'h7f;
         14: return m_pon ? 0 : regs[a];
         15: return m_pon * 16 + (m_flag && m_en());
         default: return 0;
      endcase
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input int exp);
      num_checks++;
      if (seen !== 8'(exp)) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, 8'(exp), seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // writes update the model the way the block should take them
   task automatic wr(input int a, input int d);
      host.access(1'b1, 4'(a), 8'(d), q);
      if (a == 15) begin
         if (!d[4]) m_pon = 0;
         if (!d[0]) m_flag = 0;
      end else if (!(m_pon && (a == 7 || a == 14))) regs[a] = d;
   endtask
   task automatic rchk(input int a);
      host.access(1'b0, 4'(a), 8'h00, q);
      check("register read", q, exp_rd(a));
   endtask
   task automatic pin_chk();
      check("irq a enable", irq_out_a_oe_n_o, !((m_flag && m_en()) || periodic_irq_i));
   endtask
   task automatic power_up();
      rst_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      regs = '{default: 0};
      regs[2] = 8'h12;
      regs[12] = 8'h12;
      m_pon = 1;
      m_flag = 0;
   endtask
   // one minute tick, then count edges until pin a is pulled, bounded
   task automatic tick_wait(input int nm, input int nh);
      int fire;
      regs[1] = nm;
      regs[2] = nh;
      fire = m_en() && nm == regs[11] && nh == regs[12];
      min_tick_i <= 1'b1;
      @(posedge core_clk_i);
      min_tick_i <= 1'b0;
      #1;
      n = 1;
      while (n < 1700 && irq_out_a_oe_n_o !== 1'b0) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      if (fire) m_flag = 1;
      check("alarm delay", 8'(n == (fire ? rtc_alarm_pkg::ALARM_DELAY_CYC + 2 : 1700)), 1);
      if (fire && n == 1700) print_verdict();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      power_up();
      rchk(15);
      wr(14, 8'h60);
      wr(7, 8'h15);
      rchk(14);
      rchk(7);
      check("irq b enable", irq_out_b_oe_n_o, 1);
      check("irq a value", irq_out_a_n_o, 0);
      check("irq b value", irq_out_b_n_o, 0);
      pin_chk();
      wr(15, 8'h10);
      rchk(15);
      wr(15, 8'h00);
      rchk(15);
      foreach (t_fmt[i]) begin
         wr(i < 2 ? i + 1 : i + 9, 8'hd2);
         rchk(i < 2 ? i + 1 : i + 9);
      end
      wr(9, 8'h5a);
      rchk(9);
      for (int i = 0; i < 4; i++) begin
         cm = 8'h59;
         am = 8'h00;
         if (i == 2) begin
            seed = lfsr(seed);
            cm = bcd(seed % 58);
            am = bcd(seed % 58 + 1);
         end
         wr(14, t_fmt[i] * 32); // stop first so setup cannot fire
         wr(11, am);
         wr(12, t_ah[i]); // host loads valid bcd settings
         wr(15, 0);
         wr(14, t_fmt[i] * 32 + t_en[i] * 64); // enable after the alarm settings, before the time writes
         wr(1, am);
         wr(2, t_ah[i]);
         repeat (1600) @(posedge core_clk_i);
         pin_chk();
         for (int j = 0; j < 2; j++) begin
            wr(1, cm);
            wr(2, t_ch[i]);
            tick_wait(am, t_ah[i]);
            rchk(1);
            rchk(2);
            rchk(15);
            check("irq b enable", irq_out_b_oe_n_o, 1);
            wr(15, 1);
            rchk(15);
            periodic_irq_i <= (j == 1);
            wr(15, 0);
            pin_chk();
            periodic_irq_i <= 1'b0;
            repeat (2) @(posedge core_clk_i);
            pin_chk();
         end
         wr(14, t_fmt[i] * 32); // host stops further events
         rchk(15);
         pin_chk();
      end
      irq_b_req_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      check("irq b enable", irq_out_b_oe_n_o, 0);
      power_up();
      rchk(15);
      rchk(14);
      check("irq b enable", irq_out_b_oe_n_o, 1);
      print_verdict();
   end
endmodule // tb_top

// File: common/rtc_alarm_pkg.sv
// Purpose: shared constants and types for the hour-minute alarm and power-on flag block
// Assumes: one 25 MHz core clock; register port driven by serial-bus logic on the same clock
// Notes:   register offsets are 4-bit indices; all times are held in binary-coded decimal
package rtc_alarm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [3:0] ADDR_CUR_MIN  = 4'h1;
   localparam logic [3:0] ADDR_CUR_HR   = 4'h2;
   localparam logic [3:0] ADDR_TRIM     = 4'h7;
   localparam logic [3:0] ADDR_ALM_MIN  = 4'hb;
   localparam logic [3:0] ADDR_ALM_HR   = 4'hc;
   localparam logic [3:0] ADDR_CTRL1    = 4'he;
   localparam logic [3:0] ADDR_CTRL2    = 4'hf;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int C1_HM_EN   = 6;  // hm_alarm_enable
   localparam int C1_FMT24   = 5;  // 1: 24-hour, 0: 12-hour
   localparam int C2_LOW_VOLTAGE_THRESHOLD_SEL    = 7;  // low_voltage_threshold_sel
   localparam int C2_XST     = 5;  // osc_running_n_flag
   localparam int C2_PON     = 4;  // power_on_flag
   localparam int C2_CLOCK_OUT_ENABLE_N1   = 3;  // clock_out_enable_n1
   localparam int C2_HM_FLAG = 0;  // hm_alarm_flag
   localparam int HR_BIT5    = 5;  // hour tens / afternoon indicator

   ////////////////////////////////////////////////////////////////////////////
   // values after reset
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [6:0] TRIM_RST  = 7'h00;
   localparam logic [6:0] MIN_RST   = 7'h00;
   localparam logic [5:0] HR_RST    = 6'h12;  // 12 AM, valid in the 12-hour default
   localparam logic       PON_RST   = 1'b1;
   localparam logic       XST_RST   = 1'b0;   // undefined in hardware, zero here

   ////////////////////////////////////////////////////////////////////////////
   // flag set delay after a match
   localparam int CLK_PERIOD_NS   = 40;
   localparam int ALARM_DELAY_NS  = 61000;
   localparam int ALARM_DELAY_CYC = (ALARM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [10:0] DLY_LAST = 11'(ALARM_DELAY_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // register access request, one cycle per access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

endpackage

// File: rtl/alarm_compare.sv
// Purpose: hour and minute equality between current time and alarm setting
// Assumes: both sides held in the same hour format
// Notes:   bit 5 of the hour compares as-is, its meaning follows the format bit
`timescale 1ns/1ps
module alarm_compare (
   input  wire logic [6:0] cur_min_i,
   input  wire logic [5:0] cur_hr_i,
   input  wire logic [6:0] alm_min_i,
   input  wire logic [5:0] alm_hr_i,
   input  wire logic       enable_i,
   output logic            match_o
);

   logic min_eq;
   logic hr_eq;

   ////////////////////////////////////////////////////////////////////////////
   // tens bit in 24-hour, afternoon bit in 12-hour: equal either way
   assign min_eq  = (cur_min_i == alm_min_i);
   assign hr_eq   = (cur_hr_i == alm_hr_i);
   assign match_o = enable_i && min_eq && hr_eq;

endmodule // alarm_compare

// File: rtl/hm_alarm_pon.sv
// Purpose: hour-minute alarm, power-on flag and their registers
// Assumes: reg_req_i and min_tick_i come from logic on core_clk_i
// Notes:   rst_i is the power-on reset; interrupt pins are open drain
//
// Function
// - with enable set, compare alarm hour and minute to time; match pulls irq a low
// - alarm set to current time fires only when counters next reach it
// - alarm hour bit 5 is hour tens in 24-hour, afternoon in 12-hour
// - enable at 0 (its reset value) means no comparison and no alarm interrupt
// - alarm flag sets about 61 us after an enabled match
// - alarm flag reads 0 while enable is 0
// - writing 0 clears flag, releasing irq a unless periodic irq active; 1 ignored
// - alarm flag holds 1 until the host writes 0
// - after clearing, comparator keeps running and fires again at next match
// - power-on flag sets on every power-up from 0 V
// - power-on flag holds until written 0, which re-arms; writing 1 ignored
// - while power-on flag set, trim, control 1 and control 2 apart from its power-on and oscillator flags are zero, irq pins released
// - after power-on, control 1 reads zero, control 2 only power-on flag set
// - unused bits of time and alarm registers are write-protected, read zero
// - alarm signals only on irq a; host may poll the flag instead
`timescale 1ns/1ps
module hm_alarm_pon (
   input  wire logic                      core_clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      ce_i,
   input  wire rtc_alarm_pkg::reg_req_t   reg_req_i,
   output logic                     [7:0] reg_rdata_o,
   input  wire logic                      min_tick_i,
   input  wire logic                      periodic_irq_i,
   input  wire logic                      irq_b_req_i,
   output logic                           irq_out_a_n_o,
   output logic                           irq_out_a_oe_n_o,
   output logic                           irq_out_b_n_o,
   output logic                           irq_out_b_oe_n_o
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [6:0]  cur_min_r;
   logic [5:0]  cur_hr_r;
   logic [6:0]  trim_r;
   logic [6:0]  alm_min_r;
   logic [5:0]  alm_hr_r;
   logic [7:0]  ctrl1_r;
   logic        low_voltage_threshold_sel_r;
   logic        clock_out_enable_n1_r;
   logic        xst_r;
   logic        pon_r;
   logic        hm_flag_r;
   logic        upd_r;
   logic        pend_r;
   logic [10:0] dly_cnt_r;
   logic [7:0]  rdata_r;
   logic        irq_a_oe_n_r;
   logic        irq_b_oe_n_r;
   // pin drive values; open drain so these only ever hold low, but they sit
   // in flops so every output of the block leaves a register
   logic        irq_a_val_r;
   logic        irq_b_val_r;

   ////////////////////////////////////////////////////////////////////////////
   // next values and decode
   logic [6:0]  cur_min_nxt;
   logic [5:0]  cur_hr_nxt;
   logic [6:0]  adv_min;
   logic [5:0]  adv_hr;
   logic [6:0]  trim_nxt;
   logic [7:0]  ctrl1_nxt;
   logic        low_voltage_threshold_sel_nxt;
   logic        clock_out_enable_n1_nxt;
   logic        xst_nxt;
   logic        pon_nxt;
   logic        hm_flag_nxt;
   logic        upd_nxt;
   logic        pend_nxt;
   logic [10:0] dly_cnt_nxt;
   logic [7:0]  rdata_nxt;
   logic        irq_a_oe_n_nxt;
   logic        irq_b_oe_n_nxt;

   logic        wr_cur_min;
   logic        wr_cur_hr;
   logic        wr_trim;
   logic        wr_alm_min;
   logic        wr_alm_hr;
   logic        wr_ctrl1;
   logic        wr_ctrl2;
   logic        time_wr;
   logic        tick_go;
   logic        hm_en;
   logic        fmt24;
   logic        match;
   logic        dly_done;
   logic        flag_vis;
   logic [7:0]  ctrl2_rd;
   logic [7:0]  wd;

   // write decode shared by every register
   function automatic logic hit(input rtc_alarm_pkg::reg_req_t r, input logic [3:0] a);
      hit = r.wr && (r.addr == a);
   endfunction

   assign wd         = reg_req_i.wdata;
   assign wr_cur_min = hit(reg_req_i, rtc_alarm_pkg::ADDR_CUR_MIN);
   assign wr_cur_hr  = hit(reg_req_i, rtc_alarm_pkg::ADDR_CUR_HR);
   assign wr_trim    = hit(reg_req_i, rtc_alarm_pkg::ADDR_TRIM);
   assign wr_alm_min = hit(reg_req_i, rtc_alarm_pkg::ADDR_ALM_MIN);
   assign wr_alm_hr  = hit(reg_req_i, rtc_alarm_pkg::ADDR_ALM_HR);
   assign wr_ctrl1   = hit(reg_req_i, rtc_alarm_pkg::ADDR_CTRL1);
   assign wr_ctrl2   = hit(reg_req_i, rtc_alarm_pkg::ADDR_CTRL2);

   assign hm_en = ctrl1_r[rtc_alarm_pkg::C1_HM_EN];
   assign fmt24 = ctrl1_r[rtc_alarm_pkg::C1_FMT24];

   ////////////////////////////////////////////////////////////////////////////
   // time counting; a host write to the time wins over the tick
   time_advance u_adv (
      .min_i     (cur_min_r),
      .hr_i      (cur_hr_r),
      .fmt24_i   (fmt24),
      .min_nxt_o (adv_min),
      .hr_nxt_o  (adv_hr)
   );

   assign time_wr     = wr_cur_min || wr_cur_hr;
   assign tick_go     = min_tick_i && !time_wr;
   // top bits are write-protected so they always read zero
   assign cur_min_nxt = wr_cur_min ? wd[6:0] :
                        tick_go    ? adv_min : cur_min_r;
   assign cur_hr_nxt  = wr_cur_hr  ? wd[5:0] :
                        tick_go    ? adv_hr  : cur_hr_r;

   // compare only in the cycle after the counters moved, never on a host write,
   // so programming the present time cannot fire at once
   assign upd_nxt = tick_go;

   ////////////////////////////////////////////////////////////////////////////
   // alarm comparison and delayed flag set
   alarm_compare u_cmp (
      .cur_min_i (cur_min_r),
      .cur_hr_i  (cur_hr_r),
      .alm_min_i (alm_min_r),
      .alm_hr_i  (alm_hr_r),
      .enable_i  (hm_en && upd_r),
      .match_o   (match)
   );

   // the delay is dropped if the enable goes low before it runs out
   assign dly_done    = pend_r && hm_en && (dly_cnt_r == rtc_alarm_pkg::DLY_LAST);
   assign pend_nxt    = match ? 1'b1 :
                        (!hm_en || dly_done) ? 1'b0 : pend_r;
   assign dly_cnt_nxt = match  ? 11'h000 :
                        pend_r ? dly_cnt_r + 11'h001 : dly_cnt_r;

   // set wins over a clearing write in the same cycle; writing 1 does nothing
   assign hm_flag_nxt = pon_r    ? 1'b0 :
                        dly_done ? 1'b1 :
                        (wr_ctrl2 && !wd[rtc_alarm_pkg::C2_HM_FLAG]) ? 1'b0 :
                        hm_flag_r;

   // flag is hidden while the enable is off
   assign flag_vis = hm_flag_r && hm_en;

   ////////////////////////////////////////////////////////////////////////////
   // power-on flag and the registers it holds cleared
   assign pon_nxt = (wr_ctrl2 && !wd[rtc_alarm_pkg::C2_PON]) ? 1'b0 : pon_r;

   // while the flag is set these registers are forced to their defaults
   assign trim_nxt  = pon_r ? rtc_alarm_pkg::TRIM_RST :
                      wr_trim ? wd[6:0] : trim_r;
   assign ctrl1_nxt = pon_r ? rtc_alarm_pkg::CTRL1_RST :
                      wr_ctrl1 ? wd : ctrl1_r;
   assign low_voltage_threshold_sel_nxt  = pon_r ? 1'b0 :
                      wr_ctrl2 ? wd[rtc_alarm_pkg::C2_LOW_VOLTAGE_THRESHOLD_SEL] : low_voltage_threshold_sel_r;
   assign clock_out_enable_n1_nxt = pon_r ? 1'b0 :
                      wr_ctrl2 ? wd[rtc_alarm_pkg::C2_CLOCK_OUT_ENABLE_N1] : clock_out_enable_n1_r;
   // oscillator flag is outside the power-on clear; writing 0 is ignored
   assign xst_nxt   = (wr_ctrl2 && wd[rtc_alarm_pkg::C2_XST]) ? 1'b1 : xst_r;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt pins: driven low when oe_n is 0
   // irq a stays driven while either the alarm or the periodic source is active and the power-on flag is clear
   assign irq_a_oe_n_nxt = pon_nxt ? 1'b1 :
                           !(hm_flag_nxt && ctrl1_nxt[rtc_alarm_pkg::C1_HM_EN]
                             || periodic_irq_i);
   assign irq_b_oe_n_nxt = pon_nxt ? 1'b1 : !irq_b_req_i;

   ////////////////////////////////////////////////////////////////////////////
   // read mux; unused bits and unmapped offsets read zero
   assign ctrl2_rd = {low_voltage_threshold_sel_r, 1'b0, xst_r, pon_r, clock_out_enable_n1_r, 2'b00, flag_vis};

   assign rdata_nxt =
      !reg_req_i.rd                                ? rdata_r :
      (reg_req_i.addr == rtc_alarm_pkg::ADDR_CUR_MIN) ? {1'b0, cur_min_r} :
      (reg_req_i.addr == rtc_alarm_pkg::ADDR_CUR_HR)  ? {2'b00, cur_hr_r} :
      (reg_req_i.addr == rtc_alarm_pkg::ADDR_TRIM)    ? {1'b0, trim_r} :
      (reg_req_i.addr == rtc_alarm_pkg::ADDR_ALM_MIN) ? {1'b0, alm_min_r} :
      (reg_req_i.addr == rtc_alarm_pkg::ADDR_ALM_HR)  ? {2'b00, alm_hr_r} :
      (reg_req_i.addr == rtc_alarm_pkg::ADDR_CTRL1)   ? ctrl1_r :
      (reg_req_i.addr == rtc_alarm_pkg::ADDR_CTRL2)   ? ctrl2_rd : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // time and alarm setting registers
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cur_min_r <= rtc_alarm_pkg::MIN_RST;
         cur_hr_r  <= rtc_alarm_pkg::HR_RST;
         alm_min_r <= rtc_alarm_pkg::MIN_RST;
         alm_hr_r  <= rtc_alarm_pkg::HR_RST;
      end else if (ce_i) begin
         cur_min_r <= cur_min_nxt;
         cur_hr_r  <= cur_hr_nxt;
         if (wr_alm_min) begin
            alm_min_r <= wd[6:0];
         end
         if (wr_alm_hr) begin
            alm_hr_r <= wd[5:0];
         end
      end
   end

   // control registers and power-on flag
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         trim_r  <= rtc_alarm_pkg::TRIM_RST;
         ctrl1_r <= rtc_alarm_pkg::CTRL1_RST;
         low_voltage_threshold_sel_r  <= 1'b0;
         clock_out_enable_n1_r <= 1'b0;
         xst_r   <= rtc_alarm_pkg::XST_RST;
         pon_r   <= rtc_alarm_pkg::PON_RST;
      end else if (ce_i) begin
         trim_r  <= trim_nxt;
         ctrl1_r <= ctrl1_nxt;
         low_voltage_threshold_sel_r  <= low_voltage_threshold_sel_nxt;
         clock_out_enable_n1_r <= clock_out_enable_n1_nxt;
         xst_r   <= xst_nxt;
         pon_r   <= pon_nxt;
      end
   end

   // alarm sequencing
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         upd_r     <= 1'b0;
         pend_r    <= 1'b0;
         dly_cnt_r <= 11'h000;
         hm_flag_r <= 1'b0;
      end else if (ce_i) begin
         upd_r     <= upd_nxt;
         pend_r    <= pend_nxt;
         dly_cnt_r <= dly_cnt_nxt;
         hm_flag_r <= hm_flag_nxt;
      end
   end

   // registered outputs; pins released from reset on
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r      <= 8'h00;
         irq_a_oe_n_r <= 1'b1;
         irq_b_oe_n_r <= 1'b1;
         irq_a_val_r  <= 1'b0;
         irq_b_val_r  <= 1'b0;
      end else if (ce_i) begin
         rdata_r      <= rdata_nxt;
         irq_a_oe_n_r <= irq_a_oe_n_nxt;
         irq_b_oe_n_r <= irq_b_oe_n_nxt;
         irq_a_val_r  <= 1'b0;
         irq_b_val_r  <= 1'b0;
      end
   end

   assign reg_rdata_o      = rdata_r;
   assign irq_out_a_oe_n_o = irq_a_oe_n_r;
   assign irq_out_b_oe_n_o = irq_b_oe_n_r;
   // open-drain pins only ever drive low; the enable alone sets the level
   assign irq_out_a_n_o    = irq_a_val_r;
   assign irq_out_b_n_o    = irq_b_val_r;

endmodule // hm_alarm_pon

// File: rtl/time_advance.sv
// Purpose: next minute and hour after one minute tick, in bcd
// Assumes: inputs hold valid bcd time for the selected hour format
// Notes:   purely combinational
`timescale 1ns/1ps
module time_advance (
   input  wire logic [6:0] min_i,
   input  wire logic [5:0] hr_i,
   input  wire logic       fmt24_i,
   output logic      [6:0] min_nxt_o,
   output logic      [5:0] hr_nxt_o
);

   // bcd increment of one two-digit field
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
   endfunction

   // bit 5 of the hour register: tens bit or afternoon bit
   localparam int HR_B = rtc_alarm_pkg::HR_BIT5;

   logic       hr_roll;
   logic [7:0] min_inc;
   logic [7:0] hr_inc;
   logic [7:0] h12_inc;
   logic [5:0] hr_step;
   logic [5:0] h12_step;

   ////////////////////////////////////////////////////////////////////////////
   // minute wraps at 59 and carries into the hour
   assign hr_roll   = (min_i == 7'h59);
   assign min_inc   = bcd_inc({1'b0, min_i});
   assign min_nxt_o = hr_roll ? 7'h00 : min_inc[6:0];

   // 24-hour: bit 5 is the hour tens bit, wrap at 23
   assign hr_inc = bcd_inc({2'b00, hr_i});
   // 12-hour: bit 5 is the afternoon bit, 11 flips it, 12 goes to 1
   assign h12_inc  = bcd_inc({3'b000, hr_i[4:0]});
   assign h12_step = (hr_i[4:0] == 5'h11) ? {~hr_i[HR_B], 5'h12} :
                     (hr_i[4:0] == 5'h12) ? {hr_i[HR_B], 5'h01} :
                     {hr_i[HR_B], h12_inc[4:0]};
   assign hr_step  = fmt24_i ? ((hr_i == 6'h23) ? 6'h00 : hr_inc[5:0]) : h12_step;
   assign hr_nxt_o = hr_roll ? hr_step : hr_i;

endmodule // time_advance
